//--- rtl/oscss_pkg.sv
// Functional notes
// R1 - On POR/BOR exit, pick clock from 3-bit group field and 5-bit primary mode.
// R2 - Group 000 is watch crystal, 001 fast RC; primary mode ignored outside primary.
// R3 - Group 111 with mode 00101/00110/00111 feeds fast RC through PLL x4/x8/x16.
// R4 - Start-up counter is 10 bits and counts 1024 oscillator periods before release.
// R5 - Start-up count reruns for crystal modes after POR, BOR and Sleep wake.
// R6 - Watch oscillator stays on, even in Sleep, whenever keep-on bit is set.
// R7 - Watch oscillator is device clock only with group 000 and keep-on set.
// R8 - PLL multiplies primary clock by four, eight or sixteen per primary mode.
// R9 - Read-only lock bit is set while PLL locked, clears on loss of lock.
// R10 - Device runs from fast RC whenever current group equals 001.
// R11 - Six-bit signed fast RC trim in 0.4% steps; 0 is centre.
// R12 - Software must not trim fast RC above 7.5 MHz when using x16 PLL.
// R13 - Returning from watch clock to a crystal reruns its start-up delay.
// R14 - POR/BOR loads current group and new group request from group field.
// R15 - Clock mux switches without runt pulses, output idle until new source released.
package oscss_pkg;
  localparam logic [2:0] GRP_WATCH = 3'h0;
  localparam logic [2:0] GRP_FAST_RC = 3'h1;
  localparam logic [2:0] GRP_SLOW_RC = 3'h2;
  localparam logic [2:0] GRP_PRIMARY = 3'h3;
  localparam logic [2:0] GRP_PRIMARY_PLL = 3'h7;
  localparam logic [4:0] PM_FRC_X4 = 5'h05;
  localparam logic [4:0] PM_FRC_X8 = 5'h06;
  localparam logic [4:0] PM_FRC_X16 = 5'h07;
  localparam logic [4:0] PM_XTL = 5'h00;
  localparam logic [4:0] PM_XT = 5'h04;
  localparam logic [4:0] PM_HS = 5'h02;
  localparam int STARTUP_BITS = 10;
  localparam int STARTUP_COUNT = 1024;
  localparam int TRIM_BITS = 6;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [2:0] GRP_RESET = 3'h0;
  // Source select codes for the output mux
  typedef enum logic [5:0] {
    OSCSS_SRC_NONE = 6'h01,
    OSCSS_SRC_WATCH = 6'h02,
    OSCSS_SRC_FRC = 6'h04,
    OSCSS_SRC_SLOW = 6'h08,
    OSCSS_SRC_PRI = 6'h10,
    OSCSS_SRC_PLL = 6'h20
  } oscss_src_t;
  typedef enum logic [2:0] {
    OSCSS_ST_HOLD = 3'h1,
    OSCSS_ST_WAIT = 3'h2,
    OSCSS_ST_RUN = 3'h4
  } oscss_state_t;
  // Watch group and the primary modes that are crystals; these need the start-up count
  function automatic logic oscss_is_crystal(input logic [2:0] grp, input logic [4:0] pm);
    oscss_is_crystal = (grp == GRP_WATCH) ||
      ((grp == GRP_PRIMARY || grp == GRP_PRIMARY_PLL) &&
       (pm == PM_XTL || pm == PM_XT || pm == PM_HS ||
        (grp == GRP_PRIMARY_PLL && pm[4:3] == 2'h2)));
  endfunction
endpackage

//--- rtl/oscss_startup.sv
`timescale 1ns/1ps
`default_nettype none
module oscss_startup import oscss_pkg::*; #(
  parameter int COUNT = STARTUP_COUNT
) (
  input wire logic core_clk, // System clock
  input wire logic rst, // Async reset
  input wire logic restart, // Restart count pulse
  input wire logic osc_tick, // One oscillator period
  output logic done // Count complete
);
  logic [STARTUP_BITS-1:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  always_comb begin
    cnt_next = cnt_reg;
    done_next = done_reg;
    if (restart) begin
      cnt_next = '0;
      done_next = 1'b0;
    end else if (!done_reg && osc_tick) begin
      cnt_next = cnt_reg + 1'b1; // [R4]
      if (cnt_reg == STARTUP_BITS'(COUNT - 1)) begin
        done_next = 1'b1;
      end
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end
  assign done = done_reg;
  // Count of ticks since restart, for checking
  logic [11:0] chk_ticks;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chk_ticks <= '0;
    end else if (restart) begin
      chk_ticks <= '0;
    end else if (osc_tick && !done_reg) begin
      chk_ticks <= chk_ticks + 12'h001;
    end
  end
  property p_count_exact;
    @(posedge core_clk) disable iff (rst) $rose(done_reg) |-> chk_ticks == 12'(COUNT);
  endproperty
  a_count_exact: assert property (p_count_exact) else $error("start-up count wrong"); // [R4]
  property p_restart_clears;
    @(posedge core_clk) disable iff (rst) restart |=> !done_reg;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart kept done"); // [R5]
endmodule
`default_nettype wire

//--- rtl/oscss_glitchfree_mux.sv
`timescale 1ns/1ps
`default_nettype none
module oscss_glitchfree_mux import oscss_pkg::*; (
  input wire logic core_clk, // System clock
  input wire logic rst, // Async reset
  input wire oscss_src_t want, // Requested source
  input wire logic release_ok, // Requested source stable
  output oscss_src_t active // Source driving system clock
);
  oscss_src_t act_reg, act_next;
  always_comb begin
    act_next = act_reg;
    if (want != act_reg) begin
      // Drop to idle first, never straight between two sources
      act_next = (act_reg != OSCSS_SRC_NONE) ? OSCSS_SRC_NONE :
        (release_ok ? want : OSCSS_SRC_NONE); // [R15]
    end else if (!release_ok) begin
      act_next = OSCSS_SRC_NONE; // [R15]
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act_reg <= OSCSS_SRC_NONE;
    end else begin
      act_reg <= act_next;
    end
  end
  assign active = act_reg;
  property p_no_direct_switch;
    @(posedge core_clk) disable iff (rst)
      (act_reg != OSCSS_SRC_NONE) ##1 (act_reg != $past(act_reg)) |-> act_reg == OSCSS_SRC_NONE;
  endproperty
  a_no_direct_switch: assert property (p_no_direct_switch) else $error("runt switch"); // [R15]
endmodule
`default_nettype wire

//--- rtl/oscss_top.sv
`timescale 1ns/1ps
`default_nettype none
module oscss_top import oscss_pkg::*; #(
  parameter int STARTUP_CYCLES = STARTUP_COUNT
) (
  input wire logic core_clk, // 20 MHz system clock
  input wire logic rst, // Async reset, high
  input wire logic por_bor, // Power-on or brown-out reset event
  input wire logic [2:0] osc_group_cfg, // Group configuration field
  input wire logic [4:0] primary_mode_cfg, // Primary mode field
  input wire logic [2:0] new_group_request_wr, // Written new group request
  input wire logic new_group_request_we, // Write strobe for request
  input wire logic secondary_osc_keep_on, // Keep-on control for watch osc
  input wire logic [5:0] fast_rc_trim, // Signed trim value
  input wire logic sleep, // Device in Sleep
  input wire logic osc_tick, // One primary oscillator period
  input wire logic pll_locked_in, // Raw PLL lock from analog
  output logic [2:0] current_group, // Group in effect
  output logic [2:0] new_group_request, // Requested group
  output logic pll_lock, // Read-only lock status
  output logic [4:0] pll_mult, // PLL multiplier 4, 8 or 16; 0 off
  output logic pll_from_frc, // PLL fed from fast RC
  output logic watch_osc_en, // Watch oscillator enable
  output logic fast_rc_en, // Fast RC enable
  output logic primary_osc_en, // Primary oscillator enable
  output logic [5:0] fast_rc_trim_out, // Trim to the RC
  output logic [5:0] clk_src_sel, // One-hot source, 0 = held idle
  output logic clk_ready // Clock released to system
);
  ////////////////////////////////////////////////////////////////
  logic [2:0] cur_reg, cur_next, req_reg, req_next;
  logic [4:0] pm_reg, pm_next;
  logic [5:0] trim_reg, trim_next;
  logic lock_reg, lock_next;
  logic sleep_d_reg, restart_pulse, su_done, need_su;
  oscss_src_t want_src, act_src;
  always_comb begin
    cur_next = cur_reg;
    req_next = req_reg;
    pm_next = pm_reg;
    trim_next = fast_rc_trim; // [R11]
    lock_next = pll_locked_in; // [R9]
    if (por_bor) begin
      cur_next = osc_group_cfg; // [R1] [R14]
      req_next = osc_group_cfg; // [R14]
      pm_next = primary_mode_cfg; // [R1]
    end else if (new_group_request_we) begin
      req_next = new_group_request_wr;
      cur_next = new_group_request_wr;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur_reg <= GRP_RESET;
      req_reg <= GRP_RESET;
      pm_reg <= '0;
      trim_reg <= TRIM_RESET;
      lock_reg <= 1'b0;
      sleep_d_reg <= 1'b0;
    end else begin
      cur_reg <= cur_next;
      req_reg <= req_next;
      pm_reg <= pm_next;
      trim_reg <= trim_next;
      lock_reg <= lock_next;
      sleep_d_reg <= sleep;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Start-up count restarts on POR/BOR, Sleep wake, or change back to a crystal
  logic cur_changed;
  assign cur_changed = new_group_request_we && (new_group_request_wr != cur_reg);
  assign need_su = oscss_is_crystal(cur_next, pm_next); // [R5]
  assign restart_pulse = (por_bor || (sleep_d_reg && !sleep) || cur_changed) && need_su; // [R5] [R13]
  oscss_startup #(.COUNT(STARTUP_CYCLES)) u_startup (
    .core_clk(core_clk),
    .rst(rst),
    .restart(restart_pulse),
    .osc_tick(osc_tick),
    .done(su_done)
  );
  ////////////////////////////////////////////////////////////////
  logic is_frc_pll;
  assign is_frc_pll = (cur_reg == GRP_PRIMARY_PLL) &&
    (pm_reg == PM_FRC_X4 || pm_reg == PM_FRC_X8 || pm_reg == PM_FRC_X16); // [R3]
  always_comb begin
    pll_mult = 5'h00;
    if (cur_reg == GRP_PRIMARY_PLL) begin
      case (pm_reg[1:0])
        2'h1: pll_mult = 5'h04; // [R8]
        2'h2: pll_mult = 5'h08; // [R8]
        2'h3: pll_mult = 5'h10; // [R8]
        default: pll_mult = 5'h00;
      endcase
    end
  end
  // Primary mode is only consulted for primary groups
  always_comb begin
    case (cur_reg)
      GRP_WATCH: want_src = secondary_osc_keep_on ? OSCSS_SRC_WATCH : OSCSS_SRC_NONE; // [R7]
      GRP_FAST_RC: want_src = OSCSS_SRC_FRC; // [R2] [R10]
      GRP_SLOW_RC: want_src = OSCSS_SRC_SLOW;
      GRP_PRIMARY: want_src = OSCSS_SRC_PRI;
      GRP_PRIMARY_PLL: want_src = OSCSS_SRC_PLL;
      default: want_src = OSCSS_SRC_NONE;
    endcase
  end
  // Released when crystal count done and, through PLL, when locked
  logic release_ok;
  assign release_ok = (want_src != OSCSS_SRC_NONE) &&
    (!oscss_is_crystal(cur_reg, pm_reg) || su_done) &&
    (want_src != OSCSS_SRC_PLL || lock_reg); // [R4]
  oscss_glitchfree_mux u_mux (
    .core_clk(core_clk),
    .rst(rst),
    .want(want_src),
    .release_ok(release_ok),
    .active(act_src)
  );
  ////////////////////////////////////////////////////////////////
  assign current_group = cur_reg;
  assign new_group_request = req_reg;
  assign pll_lock = lock_reg;
  assign pll_from_frc = is_frc_pll;
  assign watch_osc_en = secondary_osc_keep_on || (cur_reg == GRP_WATCH && !sleep); // [R6]
  assign fast_rc_en = (cur_reg == GRP_FAST_RC || is_frc_pll) && !sleep; // [R10]
  assign primary_osc_en = (cur_reg == GRP_PRIMARY || (cur_reg == GRP_PRIMARY_PLL && !is_frc_pll))
    && !sleep;
  // Trim passes unchecked; keeping x16 under its frequency limit is software's job
  assign fast_rc_trim_out = trim_reg; // [R12]
  assign clk_src_sel = (act_src == OSCSS_SRC_NONE) ? 6'h00 : act_src;
  assign clk_ready = (act_src != OSCSS_SRC_NONE);
  ////////////////////////////////////////////////////////////////
  property p_por_load;
    @(posedge core_clk) disable iff (rst)
      por_bor |=> current_group == $past(osc_group_cfg) && new_group_request == $past(osc_group_cfg);
  endproperty
  a_por_load: assert property (p_por_load) else $error("group not loaded"); // [R14]
  property p_watch_on;
    @(posedge core_clk) disable iff (rst) secondary_osc_keep_on |-> watch_osc_en;
  endproperty
  a_watch_on: assert property (p_watch_on) else $error("watch osc off"); // [R6]
  property p_watch_clk;
    @(posedge core_clk) disable iff (rst)
      clk_src_sel == 6'h02 |-> $past(cur_reg) == GRP_WATCH && $past(secondary_osc_keep_on);
  endproperty
  a_watch_clk: assert property (p_watch_clk) else $error("watch clock misused"); // [R7]
  property p_frc_run;
    // Mux follows the group one cycle late, so look at the group it acted on
    @(posedge core_clk) disable iff (rst) clk_src_sel == 6'h04 |-> $past(cur_reg) == GRP_FAST_RC;
  endproperty
  a_frc_run: assert property (p_frc_run) else $error("fast RC misselected"); // [R10]
  property p_frc_pll;
    @(posedge core_clk) disable iff (rst)
      cur_reg == GRP_PRIMARY_PLL && pm_reg == PM_FRC_X16 |-> pll_from_frc && pll_mult == 5'h10;
  endproperty
  a_frc_pll: assert property (p_frc_pll) else $error("fast RC x16 wrong"); // [R3]
  property p_mult;
    @(posedge core_clk) disable iff (rst)
      cur_reg == GRP_PRIMARY_PLL && pm_reg[1:0] == 2'h2 |-> pll_mult == 5'h08;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier wrong"); // [R8]
  property p_lock;
    @(posedge core_clk) disable iff (rst) !pll_locked_in |=> !pll_lock;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not cleared"); // [R9]
  property p_no_release_early;
    @(posedge core_clk) disable iff (rst)
      clk_ready && oscss_is_crystal(cur_reg, pm_reg) && !$past(restart_pulse) |-> su_done;
  endproperty
  a_no_release_early: assert property (p_no_release_early) else $error("early release"); // [R5]
  property p_trim;
    @(posedge core_clk) disable iff (rst) ##1 fast_rc_trim_out == $past(fast_rc_trim);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not applied"); // [R11]
  property p_ignore_pm;
    @(posedge core_clk) disable iff (rst) cur_reg == GRP_FAST_RC |-> pll_mult == 5'h00;
  endproperty
  a_ignore_pm: assert property (p_ignore_pm) else $error("primary mode used"); // [R2]
endmodule
`default_nettype wire

//--- dv/oscss_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module oscss_top_tb_top import oscss_pkg::*; ;
  localparam int SU = 8;
  logic core_clk, rst, por_bor, new_group_request_we, secondary_osc_keep_on;
  logic sleep, osc_tick, pll_locked_in;
  logic [2:0] osc_group_cfg, new_group_request_wr, current_group, new_group_request;
  logic [4:0] primary_mode_cfg, pll_mult;
  logic [5:0] fast_rc_trim, fast_rc_trim_out, clk_src_sel, prev_sel;
  logic pll_lock, pll_from_frc, watch_osc_en, fast_rc_en, primary_osc_en, clk_ready;
  int num_errors, checks, seed, i;
  logic [4:0] pm;
  logic [5:0] tv;
  oscss_top #(.STARTUP_CYCLES(SU)) u_oscss_top (
    .core_clk(core_clk), .rst(rst), .por_bor(por_bor), .osc_group_cfg(osc_group_cfg),
    .primary_mode_cfg(primary_mode_cfg), .new_group_request_wr(new_group_request_wr),
    .new_group_request_we(new_group_request_we), .secondary_osc_keep_on(secondary_osc_keep_on),
    .fast_rc_trim(fast_rc_trim), .sleep(sleep), .osc_tick(osc_tick),
    .pll_locked_in(pll_locked_in), .current_group(current_group),
    .new_group_request(new_group_request), .pll_lock(pll_lock), .pll_mult(pll_mult),
    .pll_from_frc(pll_from_frc), .watch_osc_en(watch_osc_en), .fast_rc_en(fast_rc_en),
    .primary_osc_en(primary_osc_en), .fast_rc_trim_out(fast_rc_trim_out),
    .clk_src_sel(clk_src_sel), .clk_ready(clk_ready));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Group 111 gain follows the low two mode bits: 01 x4, 10 x8, 11 x16
  function automatic logic [7:0] exp_mult(input logic [2:0] g, input logic [4:0] m);
    exp_mult = (g != GRP_PRIMARY_PLL || m[1:0] == 2'h0) ? 8'h00 : 8'h02 << m[1:0];
  endfunction
  task automatic por(input logic [2:0] g, input logic [4:0] m);
    @(negedge core_clk);
    osc_group_cfg = g;
    primary_mode_cfg = m;
    por_bor = 1'b1;
    @(negedge core_clk);
    por_bor = 1'b0;
    @(negedge core_clk);
    chk("current_group", {5'h00, g}, {5'h00, current_group});
    chk("new_group_request", {5'h00, g}, {5'h00, new_group_request});
    chk("pll_mult", exp_mult(g, m), {3'h0, pll_mult});
  endtask
  task automatic wr_group(input logic [2:0] g);
    @(negedge core_clk);
    new_group_request_wr = g;
    new_group_request_we = 1'b1;
    @(negedge core_clk);
    new_group_request_we = 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge core_clk);
      osc_tick = 1'b1;
      @(negedge core_clk);
      osc_tick = 1'b0;
    end
  endtask
  task automatic wait_src(input logic [5:0] exp);
    for (int k = 0; k < 40 && clk_src_sel !== exp; k++) @(negedge core_clk);
    chk("clk_src_sel", {2'h0, exp}, {2'h0, clk_src_sel});
    chk("clk_ready", 8'h01, {7'h00, clk_ready});
  endtask
  task automatic not_released();
    chk("held_not_primary", 8'h01, {7'h00, clk_src_sel !== 6'h10});
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // A direct hop between two live sources would be a runt
  always @(negedge core_clk) begin
    prev_sel <= clk_src_sel;
    if (!rst && prev_sel != 6'h00 && clk_src_sel != 6'h00 && clk_src_sel != prev_sel)
      chk("idle_between_sources", {2'h0, prev_sel}, {2'h0, clk_src_sel});
  end
  initial begin
    #(50 * 20000);
    num_errors++;
    complete_run();
  end
  initial begin
    seed = 17687;
    rst = 1'b1;
    {por_bor, new_group_request_we, secondary_osc_keep_on, sleep, osc_tick} = 5'h00;
    pll_locked_in = 1'b0;
    osc_group_cfg = 3'h0;
    primary_mode_cfg = 5'h00;
    new_group_request_wr = 3'h0;
    fast_rc_trim = 6'h00;
    prev_sel = 6'h00;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    pm = 5'($random(seed));
    por(GRP_FAST_RC, pm);
    chk("fast_rc_en", 8'h01, {7'h00, fast_rc_en});
    chk("pll_from_frc", 8'h00, {7'h00, pll_from_frc});
    wait_src(6'h04);
    for (i = 0; i < 10; i++) begin
      tv = (i == 0) ? 6'h1F : (i == 1) ? 6'h20 : (i == 2) ? 6'h00 : 6'($random(seed));
      @(negedge core_clk);
      fast_rc_trim = tv;
      {secondary_osc_keep_on, sleep} = 2'($random(seed));
      @(negedge core_clk);
      chk("fast_rc_trim_out", {2'h0, tv}, {2'h0, fast_rc_trim_out});
      chk("watch_osc_en", {7'h00, secondary_osc_keep_on}, {7'h00, watch_osc_en});
      chk("not_watch", 8'h01, {7'h00, clk_src_sel !== 6'h02});
    end
    {secondary_osc_keep_on, sleep} = 2'h0;
    fast_rc_trim = 6'h00;
    for (i = 0; i < 3; i++) begin
      pm = PM_FRC_X4 + 5'(i);
      por(GRP_PRIMARY_PLL, pm);
      chk("pll_from_frc", 8'h01, {7'h00, pll_from_frc});
      chk("primary_osc_en", 8'h00, {7'h00, primary_osc_en});
      pll_locked_in = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("pll_lock_set", 8'h01, {7'h00, pll_lock});
      wait_src(6'h20);
      pll_locked_in = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("pll_lock_clear", 8'h00, {7'h00, pll_lock});
    end
    por(GRP_PRIMARY, PM_XT);
    repeat (5) @(negedge core_clk);
    not_released();
    ticks(SU - 1);
    not_released();
    ticks(1);
    wait_src(6'h10);
    sleep = 1'b1;
    repeat (4) @(negedge core_clk);
    sleep = 1'b0;
    ticks(SU - 1);
    not_released();
    ticks(1);
    wait_src(6'h10);
    secondary_osc_keep_on = 1'b1;
    wr_group(GRP_WATCH);
    ticks(SU);
    wait_src(6'h02);
    wr_group(GRP_PRIMARY);
    ticks(SU - 1);
    not_released();
    ticks(1);
    wait_src(6'h10);
    chk("primary_osc_en", 8'h01, {7'h00, primary_osc_en});
    // Crystal behind the PLL: needs both the count and lock
    pll_locked_in = 1'b1;
    por(GRP_PRIMARY_PLL, 5'h11);
    ticks(SU - 1);
    chk("held_pll", 8'h00, {7'h00, clk_ready});
    ticks(1);
    wait_src(6'h20);
    chk("pll_primary_en", 8'h01, {7'h00, primary_osc_en});
    complete_run();
  end
endmodule
`default_nettype wire
